// File: test_timb_channel_cc.sv
// Self-checking bench for the two-channel capture/compare block.
// Assumes timb_pin_model supplies the counter and the far side of the pins.
`default_nettype none
module test_timb_channel_cc
  import timb_cc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        run = 1'b0;
  logic [1:0]  farLevel = 2'b00;
  axiReq_t     axiIn = '0;
  axiRsp_t     axiOut;
  logic [15:0] counterValue;
  logic        counterOverflow;
  logic        counterStopped;
  logic [1:0]  pinIn;
  logic [1:0]  pinOut;
  logic [1:0]  pinOutEnable;
  logic [1:0]  channelIrq;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic        lvl;
  int          err_count = 0;
  int          n_compared = 0;
  always #4 clk = ~clk;
  timb_channel_cc timb_channel_cc_inst (
    .clk(clk), .sys_rst(sys_rst), .axiIn(axiIn), .axiOut(axiOut),
    .counterValue(counterValue), .counterOverflow(counterOverflow),
    .counterStopped(counterStopped), .pinIn(pinIn), .pinOut(pinOut),
    .pinOutEnable(pinOutEnable), .channelIrq(channelIrq));
  timb_pin_model timb_pin_model_inst (
    .clk(clk), .sys_rst(sys_rst), .run(run), .farLevel(farLevel), .pinOut(pinOut),
    .pinOutEnable(pinOutEnable), .counterValue(counterValue),
    .counterOverflow(counterOverflow), .counterStopped(counterStopped), .pinIn(pinIn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail();
    err_count++;
    end_of_test();
  endtask
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    axiIn <= '{awaddr: {idx, 2'b00}, awvalid: wr, wdata: {24'h00_0000, d}, wstrb: 4'h1,
      wvalid: wr, bready: wr, araddr: {idx, 2'b00}, arvalid: !wr, rready: !wr};
    do begin
      @(posedge clk);
      i++;
      if (axiOut.awready === 1'b1) axiIn.awvalid <= 1'b0;
      if (axiOut.wready === 1'b1) axiIn.wvalid <= 1'b0;
      if (axiOut.arready === 1'b1) axiIn.arvalid <= 1'b0;
    end while (axiOut.bvalid !== 1'b1 && axiOut.rvalid !== 1'b1 && i < 64);
    rd = axiOut.rdata;
    rsp = wr ? axiOut.bresp : axiOut.rresp;
    axiIn.bready <= 1'b0;
    axiIn.rready <= 1'b0;
    if (i == 64) fail();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic setRun(input logic r);
    @(posedge clk);
    run <= r;
  endtask
  task automatic waitCnt(input logic [15:0] v);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (counterValue !== v && i < 99);
    if (i == 99) fail();
    #1;
  endtask
  task automatic testReset();
    check(pinOut, 2'b11);
    check(pinOutEnable | channelIrq, 2'b00);
    xfer(1'b0, IDX_CTRL0, 8'h00);
    check(rd, 32'h0000_0000);
    xfer(1'b0, 10'h050, 8'h00);
    check(rsp, RESP_SLVERR);
    xfer(1'b1, IDX_VAL1H, 8'hA5);
    check(rsp, RESP_OKAY);
    xfer(1'b0, IDX_VAL1H, 8'h00);
    check(rd, 32'h0000_00A5);
    xfer(1'b1, IDX_CTRL0, 8'h10);
    cycles(3);
    check({pinOut[0], pinOutEnable[0]}, 2'b00);
    xfer(1'b1, IDX_CTRL0, 8'h00);
    cycles(3);
    check({pinOut[0], pinOutEnable[0]}, 2'b10);
    $display("reset test done");
  endtask
  task automatic testCapture();
    for (int c = 1; c < 4; c++) begin
      @(posedge clk);
      farLevel[1] <= (c == 3);
      setRun(1'b0);
      xfer(1'b0, IDX_CTRL1, 8'h00);
      xfer(1'b1, IDX_CTRL1, {4'h4, c[1:0], 2'b00});
      cycles(2);
      setRun(1'b1);
      @(posedge clk);
      farLevel[1] <= (c != 3);
      cycles(8);
      check(channelIrq[1], c != 2);
      @(posedge clk);
      farLevel[1] <= (c == 3);
      cycles(8);
      check(channelIrq[1], 1'b1);
    end
    xfer(1'b0, IDX_CTRL1, 8'h00);
    check(rd[7], 1'b1);
    xfer(1'b1, IDX_CTRL1, 8'h00);
    cycles(3);
    check(channelIrq[1], 1'b0);
    xfer(1'b1, IDX_CTRL1, 8'h04);
    xfer(1'b0, IDX_VAL1H, 8'h00);
    @(posedge clk);
    farLevel[1] <= 1'b0;
    cycles(8);
    @(posedge clk);
    farLevel[1] <= 1'b1;
    cycles(8);
    xfer(1'b0, IDX_CTRL1, 8'h00);
    check(rd[7], 1'b0);
    xfer(1'b0, IDX_VAL1L, 8'h00);
    @(posedge clk);
    farLevel[1] <= 1'b0;
    cycles(8);
    @(posedge clk);
    farLevel[1] <= 1'b1;
    cycles(8);
    xfer(1'b0, IDX_CTRL1, 8'h00);
    check(rd[7], 1'b1);
    xfer(1'b1, IDX_CTRL1, 8'h00);
    $display("capture test done");
  endtask
  task automatic testCompare();
    xfer(1'b1, IDX_VAL0H, 8'h00);
    xfer(1'b1, IDX_VAL0L, 8'h10);
    for (int c = 3; c > 0; c--) begin
      setRun(1'b0);
      xfer(1'b0, IDX_CTRL0, 8'h00);
      check(rd[7], c != 3);
      xfer(1'b1, IDX_CTRL0, {4'h1, c[1:0], 2'b00});
      cycles(2);
      lvl = pinOut[0];
      setRun(1'b1);
      waitCnt(16'h0012);
      check(pinOut[0], c == 3 ? 1'b1 : c == 2 ? 1'b0 : !lvl);
    end
    setRun(1'b0);
    xfer(1'b0, IDX_CTRL0, 8'h00);
    xfer(1'b1, IDX_CTRL0, 8'h54);
    xfer(1'b1, IDX_VAL0H, 8'h00);
    setRun(1'b1);
    waitCnt(16'h0012);
    check(channelIrq[0], 1'b0);
    xfer(1'b1, IDX_VAL0L, 8'h10);
    waitCnt(16'h0012);
    check(channelIrq[0], 1'b1);
    xfer(1'b1, IDX_CTRL0, 8'h14);
    cycles(3);
    check(channelIrq[0], 1'b0);
    $display("compare test done");
  endtask
  task automatic testOverflow();
    for (int k = 0; k < 2; k++) begin
      setRun(1'b0);
      xfer(1'b1, IDX_VAL0L, k ? 8'h00 : 8'h10);
      xfer(1'b1, IDX_CTRL0, 8'h16);
      setRun(1'b1);
      waitCnt(16'h0008);
      lvl = pinOut[0];
      waitCnt(16'h0008);
      check(pinOut[0], k ? !lvl : lvl);
    end
    setRun(1'b0);
    xfer(1'b1, IDX_VAL0L, 8'h10);
    xfer(1'b1, IDX_CTRL0, 8'h18);
    setRun(1'b1);
    waitCnt(16'h0014);
    xfer(1'b1, IDX_CTRL0, 8'h19);
    waitCnt(16'h001E);
    check(pinOut[0], 1'b0);
    waitCnt(16'h0002);
    check(pinOut[0], 1'b1);
    $display("overflow test done");
  endtask
  task automatic testBuffered();
    setRun(1'b0);
    xfer(1'b1, IDX_CTRL1, 8'h1C);
    xfer(1'b1, IDX_CTRL0, 8'h2C);
    xfer(1'b0, IDX_CTRL1, 8'h00);
    check(rd, 32'h0000_0000);
    check(pinOutEnable, 2'b01);
    xfer(1'b1, IDX_CTRL0, 8'h00);
    xfer(1'b1, IDX_CTRL1, 8'h20);
    xfer(1'b0, IDX_CTRL1, 8'h00);
    check(rd[5], 1'b0);
    $display("buffered test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    testReset();
    testCapture();
    testCompare();
    testOverflow();
    testBuffered();
    end_of_test();
  end
endmodule
`default_nettype wire

// File: timb_cc_assertions.sv
// Concurrent checks on the ports of the capture/compare block.
// Assumes one clk domain and synchronous active-high sys_rst.
`default_nettype none
module timb_cc_checker
  import timb_cc_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire axiReq_t     axiIn,
  input wire axiRsp_t     axiOut,
  input wire logic [15:0] counterValue,
  input wire logic        counterOverflow,
  input wire logic        counterStopped,
  input wire logic [1:0]  pinIn,
  input wire logic [1:0]  pinOut,
  input wire logic [1:0]  pinOutEnable,
  input wire logic [1:0]  channelIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wrTaken;
  logic wrCtrl0;
  logic wrCtrl1;
  logic rdTaken;
  logic [9:0] rdIdx;
  assign wrTaken = axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready;
  assign wrCtrl0 = wrTaken && axiIn.awaddr[11:2] == IDX_CTRL0 && axiIn.wstrb[0];
  assign wrCtrl1 = wrTaken && axiIn.awaddr[11:2] == IDX_CTRL1 && axiIn.wstrb[0];
  assign rdTaken = axiIn.arvalid && axiOut.arready;
  assign rdIdx = axiIn.araddr[11:2];
  a_reset_outputs: assert property (disable iff (1'b0) sys_rst |=> pinOut == 2'b11
    && pinOutEnable == 2'b00 && channelIrq == 2'b00) else $error("reset outputs wrong");
  a_read_answer: assert property (rdTaken |=> axiOut.rvalid)
    else $error("read not answered");
  a_write_answer: assert property (wrTaken |-> ##[1:2] axiOut.bvalid)
    else $error("write not answered");
  a_unmapped_read: assert property (rdTaken && (rdIdx < IDX_CTRL0 || rdIdx > IDX_VAL1L)
    |=> axiOut.rresp == RESP_SLVERR && axiOut.rdata == 32'h0000_0000) else $error("bad slverr");
  a_read_held: assert property (axiOut.rvalid && !axiIn.rready |=> axiOut.rvalid
    && $stable(axiOut.rdata)) else $error("read data not held");
  a_irq_disable: assert property (wrCtrl0 && !axiIn.wdata[6] |-> ##[2:4] !channelIrq[0])
    else $error("irq stays without enable");
  a_preset_low: assert property (wrCtrl0 && axiIn.wdata[5:2] == 4'h4
    |-> ##[2:4] !pinOut[0] && !pinOutEnable[0]) else $error("preset low wrong");
  a_port_owns_pin: assert property (wrCtrl0 && axiIn.wdata[3:2] == ELS_OFF
    |-> ##[2:4] !pinOutEnable[0]) else $error("pin not released");
  a_compare_drives: assert property (wrCtrl0 && axiIn.wdata[5:4] != 2'b00
    && axiIn.wdata[3:2] != ELS_OFF |-> ##[2:4] pinOutEnable[0]) else $error("pin not driven");
  a_capture_listens: assert property (wrCtrl1 && !axiIn.wdata[4]
    |-> ##[2:4] !pinOutEnable[1]) else $error("capture pin driven");
  a_buffered_frees: assert property (wrCtrl0 && axiIn.wdata[5] |-> ##[2:4] !pinOutEnable[1])
    else $error("channel 1 pin kept");
  c_capture_irq: cover property ($rose(channelIrq[1]));
  c_compare_drive: cover property ($rose(pinOutEnable[0]));
  c_unmapped: cover property (axiOut.rvalid && axiOut.rresp == RESP_SLVERR);
endmodule

bind timb_channel_cc timb_cc_checker timb_cc_checker_inst (
  .clk             (clk),
  .sys_rst         (sys_rst),
  .axiIn           (axiIn),
  .axiOut          (axiOut),
  .counterValue    (counterValue),
  .counterOverflow (counterOverflow),
  .counterStopped  (counterStopped),
  .pinIn           (pinIn),
  .pinOut          (pinOut),
  .pinOutEnable    (pinOutEnable),
  .channelIrq      (channelIrq)
);
`default_nettype wire

// File: timb_cc_pkg.sv
// Constants and carrier types for the two-channel timer capture/compare block.
// Assumes a single synchronous clock domain and a 32-bit AXI4-Lite register bus.
`default_nettype none

package timb_cc_pkg;

  localparam int NCH    = 2;
  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL0 = 10'h045;
  localparam logic [9:0] IDX_VAL0H = 10'h046;
  localparam logic [9:0] IDX_VAL0L = 10'h047;
  localparam logic [9:0] IDX_CTRL1 = 10'h048;
  localparam logic [9:0] IDX_VAL1H = 10'h049;
  localparam logic [9:0] IDX_VAL1L = 10'h04A;

  // Channel control/status bit positions
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE   = 6;
  localparam int BIT_MSB  = 5;
  localparam int BIT_MSA  = 4;
  localparam int BIT_ELSB = 3;
  localparam int BIT_ELSA = 2;
  localparam int BIT_TOV  = 1;
  localparam int BIT_MAX  = 0;

  // Edge/level codes: capture edge or compare action
  localparam logic [1:0] ELS_OFF    = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR  = 2'h2;
  localparam logic [1:0] ELS_SET    = 2'h3;

  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic        LEVEL_RESET = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_BUFFERED
  } chanMode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axiReq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axiRsp_t;

endpackage

`default_nettype wire

// File: timb_channel_cc.sv
// Two-channel capture/compare/PWM logic with an AXI4-Lite register slave.
// Assumes the shared counter, its overflow pulse and stop state come from
// logic on the same clock; channel pins arrive asynchronously.
//
// Behaviour
// - Per-channel interrupt enable bit, read/write, cleared by reset.
// - Buffered-mode select exists only on channel 0 and enables buffered compare/PWM.
// - Buffered mode disables channel 1 control register and frees its pin.
// - With edge/level nonzero, mode bit chooses compare/PWM (1) or capture (0).
// - With edge/level zero, mode bit presets output: 1 low, 0 high.
// - Capture edge: 01 rising, 10 falling, 11 either edge.
// - Compare action on match: 01 toggle, 10 clear, 11 set.
// - Edge/level zero disconnects pin; channel holds preset level meanwhile.
// - Toggle-on-overflow toggles compare output at overflow; ignored in capture.
// - Overflow toggle wins over a coincident compare match.
// - Max-duty bit forces full duty for clear/set actions when toggle-on-overflow is off.
// - Max-duty change takes effect from the next PWM period.
// - Each channel has a 16-bit read/write value register.
// - Capture mode: reading high byte blocks captures until low byte read.
// - Compare mode: writing high byte blocks matches until low byte written.
// - Reset clears mode and edge bits; pin under port, level high.
// - Flag sets on event; clears by read-then-write-0; new event wins.
`default_nettype none

module timb_channel_cc
  import timb_cc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire axiReq_t     axiIn,
  output var  axiRsp_t     axiOut,
  input  wire logic [15:0] counterValue,
  input  wire logic        counterOverflow,
  input  wire logic        counterStopped,
  input  wire logic [1:0]  pinIn,
  output var  logic [1:0]  pinOut,
  output var  logic [1:0]  pinOutEnable,
  output var  logic [1:0]  channelIrq
);

  // Channel control state
  logic [1:0]  flag;
  logic [1:0]  irqEn;
  logic [1:0]  msA;
  logic        msB0;
  logic [1:0]  els [NCH];
  logic [1:0]  tov;
  logic [1:0]  maxDuty;
  logic [1:0]  armClear;
  logic [1:0]  maxActive;

  // Value registers and coherency locks
  logic [15:0] value [NCH];
  logic [15:0] bufValue;
  logic        bufSel;
  logic [1:0]  capLock;
  logic [1:0]  cmpLock;

  // Pin synchroniser
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  pinPrev;

  // Bus slave state
  logic        awReady;
  logic        wReady;
  logic        bValid;
  logic [1:0]  bResp;
  logic        arReady;
  logic        rValid;
  logic [7:0]  rByte;
  logic [1:0]  rResp;
  logic [9:0]  awIdx;
  logic [7:0]  wByte;
  logic        wLane;

  // Combinational
  chanMode_t   mode [NCH];
  logic [1:0]  capEvent;
  logic [1:0]  cmpMatch;
  logic [1:0]  chanEvent;
  logic [1:0]  wrCtrl;
  logic [1:0]  wrHigh;
  logic [1:0]  wrLow;
  logic [1:0]  rdCtrl;
  logic [1:0]  rdHigh;
  logic [1:0]  rdLow;
  logic        wrFire;
  logic        wrEn;
  logic        rdFire;
  logic [9:0]  rdIdx;
  logic [7:0]  next_rByte;

  function automatic logic isMapped(input logic [9:0] idx);
    isMapped = (idx == IDX_CTRL0) || (idx == IDX_VAL0H) || (idx == IDX_VAL0L) ||
               (idx == IDX_CTRL1) || (idx == IDX_VAL1H) || (idx == IDX_VAL1L);
  endfunction

  assign axiOut = '{awready: awReady, wready: wReady, bresp: bResp, bvalid: bValid,
                    arready: arReady, rdata: {24'h00_0000, rByte}, rresp: rResp,
                    rvalid: rValid};

  // Mode decode per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if ((c == 1 && msB0) || els[c] == ELS_OFF) begin
        mode[c] = MODE_OFF;
      end else if (c == 0 && msB0) begin
        mode[c] = MODE_BUFFERED;
      end else if (msA[c]) begin
        mode[c] = MODE_COMPARE;
      end else begin
        mode[c] = MODE_CAPTURE;
      end
    end
  end

  // Capture edges and compare matches
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      capEvent[c] = (mode[c] == MODE_CAPTURE) && !counterStopped && !capLock[c] &&
                    ((els[c][0] && sync2[c] && !pinPrev[c]) ||
                     (els[c][1] && !sync2[c] && pinPrev[c]));
      cmpMatch[c] = (mode[c] == MODE_COMPARE || mode[c] == MODE_BUFFERED) &&
                    !cmpLock[c] &&
                    (counterValue == ((mode[c] == MODE_BUFFERED) ? bufValue : value[c]));
      chanEvent[c] = capEvent[c] || cmpMatch[c];
    end
  end

  // Bus decode
  assign wrFire = !awReady && !wReady && !bValid;
  assign wrEn   = wrFire && wLane && isMapped(awIdx);
  assign rdFire = axiIn.arvalid && arReady;
  assign rdIdx  = axiIn.araddr[11:2];

  always_comb begin
    wrCtrl[0] = wrEn && awIdx == IDX_CTRL0;
    wrCtrl[1] = wrEn && awIdx == IDX_CTRL1 && !msB0;
    wrHigh[0] = wrEn && awIdx == IDX_VAL0H;
    wrHigh[1] = wrEn && awIdx == IDX_VAL1H;
    wrLow[0]  = wrEn && awIdx == IDX_VAL0L;
    wrLow[1]  = wrEn && awIdx == IDX_VAL1L;
    rdCtrl[0] = rdFire && rdIdx == IDX_CTRL0;
    rdCtrl[1] = rdFire && rdIdx == IDX_CTRL1 && !msB0;
    rdHigh[0] = rdFire && rdIdx == IDX_VAL0H;
    rdHigh[1] = rdFire && rdIdx == IDX_VAL1H;
    rdLow[0]  = rdFire && rdIdx == IDX_VAL0L;
    rdLow[1]  = rdFire && rdIdx == IDX_VAL1L;
  end

  always_comb begin
    unique case (rdIdx)
      IDX_CTRL0: next_rByte = {flag[0], irqEn[0], msB0, msA[0], els[0], tov[0], maxDuty[0]};
      IDX_CTRL1: next_rByte = msB0 ? 8'h00 :
                              {flag[1], irqEn[1], 1'b0, msA[1], els[1], tov[1], maxDuty[1]};
      IDX_VAL0H: next_rByte = value[0][15:8];
      IDX_VAL0L: next_rByte = value[0][7:0];
      IDX_VAL1H: next_rByte = value[1][15:8];
      IDX_VAL1L: next_rByte = value[1][7:0];
      default:   next_rByte = 8'h00;
    endcase
  end

  // AXI4-Lite write channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awReady <= 1'b1;
      wReady  <= 1'b1;
      bValid  <= 1'b0;
      bResp   <= RESP_OKAY;
      awIdx   <= 10'h000;
      wByte   <= 8'h00;
      wLane   <= 1'b0;
    end else begin
      if (axiIn.awvalid && awReady) begin
        awReady <= 1'b0;
        awIdx   <= axiIn.awaddr[11:2];
      end else if (wrFire) begin
        awReady <= 1'b1;
      end
      if (axiIn.wvalid && wReady) begin
        wReady <= 1'b0;
        wByte  <= axiIn.wdata[7:0];
        wLane  <= axiIn.wstrb[0];
      end else if (wrFire) begin
        wReady <= 1'b1;
      end
      if (wrFire) begin
        bValid <= 1'b1;
        bResp  <= isMapped(awIdx) ? RESP_OKAY : RESP_SLVERR;
      end else if (axiIn.bready) begin
        bValid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arReady <= 1'b1;
      rValid  <= 1'b0;
      rByte   <= 8'h00;
      rResp   <= RESP_OKAY;
    end else if (rdFire) begin
      arReady <= 1'b0;
      rValid  <= 1'b1;
      rByte   <= next_rByte;
      rResp   <= isMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid && axiIn.rready) begin
      arReady <= 1'b1;
      rValid  <= 1'b0;
    end
  end

  // Channel control/status registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag     <= 2'h0;
      irqEn    <= 2'h0;
      msA      <= 2'h0;
      msB0     <= CTRL_RESET[BIT_MSB];
      els[0]   <= ELS_OFF;
      els[1]   <= ELS_OFF;
      tov      <= 2'h0;
      maxDuty  <= 2'h0;
      armClear <= 2'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (chanEvent[c]) begin
          flag[c] <= 1'b1;
        end else if (wrCtrl[c] && !wByte[BIT_FLAG] && armClear[c]) begin
          flag[c] <= 1'b0;
        end
        if (wrCtrl[c]) begin
          armClear[c] <= 1'b0;
        end else if (rdCtrl[c] && flag[c]) begin
          armClear[c] <= 1'b1;
        end
        if (wrCtrl[c]) begin
          irqEn[c]   <= wByte[BIT_IE];
          msA[c]     <= wByte[BIT_MSA];
          els[c]     <= wByte[BIT_ELSB:BIT_ELSA];
          tov[c]     <= wByte[BIT_TOV];
          maxDuty[c] <= wByte[BIT_MAX];
        end
      end
      if (wrCtrl[0]) begin
        msB0 <= wByte[BIT_MSB];
      end
    end
  end

  // Value registers, buffered compare value and coherency locks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value[0] <= VALUE_RESET;
      value[1] <= VALUE_RESET;
      bufValue <= VALUE_RESET;
      bufSel   <= 1'b0;
      capLock  <= 2'h0;
      cmpLock  <= 2'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (capEvent[c]) begin
          value[c] <= counterValue;
        end
        if (wrHigh[c]) begin
          value[c][15:8] <= wByte;
        end
        if (wrLow[c]) begin
          value[c][7:0] <= wByte;
        end
        if (rdLow[c]) begin
          capLock[c] <= 1'b0;
        end else if (rdHigh[c] && mode[c] == MODE_CAPTURE) begin
          capLock[c] <= 1'b1;
        end
        if (wrLow[c]) begin
          cmpLock[c] <= 1'b0;
        end else if (wrHigh[c] && (msA[c] || (c == 0 && msB0))) begin
          cmpLock[c] <= 1'b1;
        end
      end
      // Buffered compare swaps in the last completed value at period end
      if (wrLow[0]) begin
        bufSel <= 1'b0;
      end else if (wrLow[1]) begin
        bufSel <= 1'b1;
      end
      if (!msB0 || counterOverflow) begin
        bufValue <= bufSel ? value[1] : value[0];
      end
    end
  end

  // Pin input synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1   <= 2'h0;
      sync2   <= 2'h0;
      pinPrev <= 2'h0;
    end else begin
      sync1   <= pinIn;
      sync2   <= sync1;
      pinPrev <= sync2;
    end
  end

  // Channel output level, pin ownership and interrupt request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinOut       <= {NCH{LEVEL_RESET}};
      pinOutEnable <= 2'h0;
      maxActive    <= 2'h0;
      channelIrq   <= 2'h0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (counterOverflow) begin
          maxActive[c] <= maxDuty[c];
        end
        pinOutEnable[c] <= (mode[c] == MODE_COMPARE) || (mode[c] == MODE_BUFFERED);
        channelIrq[c]   <= flag[c] && irqEn[c];
        unique case (mode[c])
          MODE_OFF: begin
            pinOut[c] <= !msA[c];
          end
          MODE_CAPTURE: begin
            pinOut[c] <= pinOut[c];
          end
          MODE_COMPARE, MODE_BUFFERED: begin
            if (counterOverflow && tov[c]) begin
              pinOut[c] <= !pinOut[c];
            end else if (maxActive[c] && !tov[c]) begin
              // Full duty: hold the level opposite to the one the match action would leave
              if (els[c] == ELS_CLEAR) begin
                pinOut[c] <= 1'b1;
              end else if (els[c] == ELS_SET) begin
                pinOut[c] <= 1'b0;
              end
            end else if (cmpMatch[c]) begin
              unique case (els[c])
                ELS_TOGGLE: pinOut[c] <= !pinOut[c];
                ELS_CLEAR:  pinOut[c] <= 1'b0;
                ELS_SET:    pinOut[c] <= 1'b1;
                default:    pinOut[c] <= pinOut[c];
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: timb_pin_model.sv
// Far-side model: shared counter source and external channel pin levels.
// Assumes the bench sets run and farLevel at rising clock edges.
`default_nettype none
module timb_pin_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        run,
  input  wire logic [1:0]  farLevel,
  input  wire logic [1:0]  pinOut,
  input  wire logic [1:0]  pinOutEnable,
  output var  logic [15:0] counterValue,
  output var  logic        counterOverflow,
  output wire logic        counterStopped,
  output wire logic [1:0]  pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MODULO = 16'h001F;
  // Stopping also clears the count, as stop plus counter reset does
  always @(posedge clk) begin
    if (sys_rst || !run || counterValue == MODULO) begin
      counterValue <= 16'h0000;
    end else begin
      counterValue <= counterValue + 16'h0001;
    end
    counterOverflow <= !sys_rst && run && counterValue == MODULO;
  end
  assign counterStopped = !run;
  // Timer level while driven, far side level otherwise
  assign pinIn = (pinOutEnable & pinOut) | (~pinOutEnable & farLevel);
endmodule
`default_nettype wire
